// File: hdl/bhmac_cfg.svh
// register indices, field positions, reset values and fixed codes of the hdlc mode block
`ifndef BHMAC_CFG_SVH
`define BHMAC_CFG_SVH

// register indices; the byte address on the bus is four times the index
`define BHMAC_IDX_MODE        10'h072
`define BHMAC_IDX_EXT_MODE    10'h073
`define BHMAC_IDX_LOW_FIRST   10'h074
`define BHMAC_IDX_HIGH_FIRST  10'h075
`define BHMAC_IDX_HIGH_SECOND 10'h076
`define BHMAC_IDX_COUNT_LOW   10'h076
`define BHMAC_IDX_COUNT_HIGH  10'h077
`define BHMAC_IDX_LOW_SECOND  10'h078

// reset values
`define BHMAC_RST_MODE        8'hC0
`define BHMAC_RST_EXT_MODE    8'h00
`define BHMAC_RST_ADDR        8'h00
`define BHMAC_RST_HIGH_RESULT 2'h3
`define BHMAC_RST_LOW_RESULT  1'h0

// field positions
`define BHMAC_MODE_SEL_HI     7
`define BHMAC_MODE_SEL_LO     5
`define BHMAC_MODE_RX_EN      3
`define BHMAC_EXT_TX_BLK      7
`define BHMAC_EXT_RX_BLK_HI   6
`define BHMAC_EXT_RX_BLK_LO   5
`define BHMAC_EXT_STORE_ADDR  4
`define BHMAC_EXT_TX_CRC_OFF  3
`define BHMAC_EXT_RX_CRC_KEEP 2
`define BHMAC_EXT_FILL_SEL    0
`define BHMAC_ADDR_MASK_BIT   0
`define BHMAC_ADDR_HIGH_HI    7
`define BHMAC_ADDR_HIGH_LO    2

// fixed codes
`define BHMAC_HIGH_GROUP      6'h3F
`define BHMAC_LOW_GROUP       8'hFF
`define BHMAC_FLAG_PATTERN    8'h7E
`define BHMAC_TX_BLK_BIG      7'h40
`define BHMAC_TX_BLK_SMALL    7'h20
`define BHMAC_RX_BLK_MASK     6'h3F
`define BHMAC_HIGH_RES_FIRST  2'h2
`define BHMAC_HIGH_RES_SECOND 2'h0
`define BHMAC_HIGH_RES_GROUP  2'h1

`endif

// File: hdl/bhmac_mode_address_ctrl.sv
// b-channel hdlc mode, address recognition and receive byte count block
`include "bhmac_cfg.svh"

module bhmac_mode_address_ctrl #(
    parameter int CNT_W = 12
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // command strobes
    input  wire logic        rx_message_complete,
    input  wire logic        receiver_reset_cmd,
    input  wire logic        tx_message_end,
    input  wire logic        transmitter_reset_cmd,
    input  wire logic        tx_transparent_frame,
    // received byte stream
    input  wire logic        rx_in_valid,
    input  wire logic [7:0]  rx_in_data,
    input  wire logic        rx_in_first,
    input  wire logic        rx_in_last,
    input  wire logic        rx_in_crc,
    // towards receive fifo and events
    output logic             rx_fifo_valid,
    output logic      [7:0]  rx_fifo_data,
    output logic             rx_message_end,
    output logic             rx_pool_full,
    output logic      [1:0]  high_match_result,
    output logic             low_match_result,
    output logic             low_match_command,
    // block sizes and transmit side settings
    output logic      [6:0]  tx_block_bytes,
    output logic      [6:0]  rx_block_bytes,
    output logic             tx_crc_append,
    input  wire logic        tx_bit_strobe,
    output logic             tx_fill_bit
);

    // ==========================================================
    // reset release
    logic rst_ff1;
    logic rst_n_sync;

    // two stages so the release never meets a clock edge mid-flight
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_ff1    <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_ff1    <= 1'b1;
            rst_n_sync <= rst_ff1;
        end
    end

    // ==========================================================
    // apb register file
    logic [7:0]       mode_reg;
    logic [7:0]       ext_mode;
    logic [7:0]       high_first;
    logic [7:0]       high_second;
    logic [7:0]       low_first;
    logic [7:0]       low_second;
    logic [CNT_W-1:0] snap_count;
    logic             snap_ov;
    logic [9:0]       idx;
    logic             wr_acc;
    logic             hit;
    logic [7:0]       rd_byte;

    assign idx    = paddr[11:2];
    assign wr_acc = psel && penable && pwrite && pready;

    // read mux and decode; write-only high first and low second read as zero, high second shares its index with count low
    always_comb begin
        hit     = (paddr[1:0] == 2'h0);
        rd_byte = 8'h00;
        case (idx)
            `BHMAC_IDX_MODE:        rd_byte = mode_reg;
            `BHMAC_IDX_EXT_MODE:    rd_byte = ext_mode;
            `BHMAC_IDX_LOW_FIRST:   rd_byte = low_first;
            `BHMAC_IDX_HIGH_FIRST:  rd_byte = 8'h00;
            `BHMAC_IDX_COUNT_LOW:   rd_byte = snap_count[7:0];
            `BHMAC_IDX_COUNT_HIGH:  rd_byte = {3'h0, snap_ov, snap_count[CNT_W-1:8]};
            `BHMAC_IDX_LOW_SECOND:  rd_byte = 8'h00;
            default:                hit = 1'b0;
        endcase
    end

    // zero-wait answer: registered in setup, shown in the access cycle
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // software written settings; unused bits are kept at zero
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            mode_reg    <= `BHMAC_RST_MODE;
            ext_mode    <= `BHMAC_RST_EXT_MODE;
            high_first  <= `BHMAC_RST_ADDR;
            high_second <= `BHMAC_RST_ADDR;
            low_first   <= `BHMAC_RST_ADDR;
            low_second  <= `BHMAC_RST_ADDR;
        end else if (wr_acc && paddr[1:0] == 2'h0) begin
            case (idx)
                `BHMAC_IDX_MODE:        mode_reg    <= pwdata[7:0] & 8'hE8;
                `BHMAC_IDX_EXT_MODE:    ext_mode    <= pwdata[7:0] & 8'hFD;
                `BHMAC_IDX_HIGH_FIRST:  high_first  <= pwdata[7:0] & 8'hFD;
                `BHMAC_IDX_HIGH_SECOND: high_second <= pwdata[7:0] & 8'hFD;
                `BHMAC_IDX_LOW_FIRST:   low_first   <= pwdata[7:0];
                `BHMAC_IDX_LOW_SECOND:  low_second  <= pwdata[7:0];
                default:                mode_reg    <= mode_reg;
            endcase
        end
    end

    // ==========================================================
    // block sizes and transmit settings
    logic       tx_cmd;
    logic       rx_cmd;
    logic       tx_blk_eff;
    logic [1:0] rx_blk_eff;
    logic [5:0] rx_blk_mask;
    logic [2:0] fill_phase;
    logic [7:0] flag_pat;

    assign tx_cmd      = tx_message_end || transmitter_reset_cmd || tx_transparent_frame;
    assign rx_cmd      = rx_message_complete || receiver_reset_cmd;
    assign rx_blk_mask = `BHMAC_RX_BLK_MASK >> rx_blk_eff;
    assign flag_pat    = `BHMAC_FLAG_PATTERN;

    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            tx_blk_eff <= 1'b0;
            rx_blk_eff <= 2'h0;
        end else begin
            if (tx_cmd) begin
                tx_blk_eff <= ext_mode[`BHMAC_EXT_TX_BLK];
            end
            if (rx_cmd) begin
                rx_blk_eff <= ext_mode[`BHMAC_EXT_RX_BLK_HI:`BHMAC_EXT_RX_BLK_LO];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            tx_block_bytes <= `BHMAC_TX_BLK_BIG;
            rx_block_bytes <= `BHMAC_TX_BLK_BIG;
            tx_crc_append  <= 1'b1;
        end else begin
            tx_block_bytes <= tx_blk_eff ? `BHMAC_TX_BLK_SMALL : `BHMAC_TX_BLK_BIG;
            rx_block_bytes <= {1'b0, rx_blk_mask} + 7'h01;
            tx_crc_append  <= !ext_mode[`BHMAC_EXT_TX_CRC_OFF];
        end
    end

    // interframe fill, one bit per strobe
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            fill_phase  <= 3'h0;
            tx_fill_bit <= 1'b1;
        end else if (tx_bit_strobe) begin
            fill_phase  <= fill_phase + 3'h1;
            tx_fill_bit <= ext_mode[`BHMAC_EXT_FILL_SEL] ? flag_pat[fill_phase] : 1'b1;
        end
    end

    // ==========================================================
    // address recognition
    bhmac_pkg::bhmac_mode_e      mode;
    bhmac_pkg::bhmac_rx_state_e  rx_state;
    bhmac_pkg::bhmac_rx_state_e  cur_state;
    bhmac_pkg::bhmac_rx_state_e  next_rx_state;
    logic       hi_cmp;
    logic       lo_cmp;
    logic       two_addr;
    logic       start;
    logic       hi_m1;
    logic       hi_m2;
    logic       hi_grp;
    logic       lo_m1;
    logic       lo_m2;
    logic       lo_grp;
    logic [5:0] hi_addr;
    logic [5:0] hi_mask;
    logic [7:0] lo_mask;

    assign mode    = bhmac_pkg::bhmac_mode_e'(mode_reg[`BHMAC_MODE_SEL_HI:`BHMAC_MODE_SEL_LO]);
    assign start   = rx_in_valid && rx_in_first;
    assign hi_addr = rx_in_data[`BHMAC_ADDR_HIGH_HI:`BHMAC_ADDR_HIGH_LO];

    // high values only in two modes
    assign hi_cmp   = (mode == bhmac_pkg::MODE_NONAUTO2) || (mode == bhmac_pkg::MODE_TRANS1);
    assign lo_cmp   = (mode == bhmac_pkg::MODE_NONAUTO1) || (mode == bhmac_pkg::MODE_NONAUTO2)
                   || (mode == bhmac_pkg::MODE_TRANS2);
    assign two_addr = hi_cmp || (mode == bhmac_pkg::MODE_TRANS2);

    assign hi_mask = high_first[`BHMAC_ADDR_MASK_BIT] ? high_second[7:2] : 6'h00;
    assign hi_m1   = ((hi_addr ^ high_first[7:2]) & ~hi_mask) == 6'h00;
    assign hi_m2   = !high_first[`BHMAC_ADDR_MASK_BIT] && (hi_addr == high_second[7:2]);
    // high group value, the c/r bit is don't-care so FC and FE both hit
    assign hi_grp  = (hi_addr == `BHMAC_HIGH_GROUP);

    assign lo_mask = high_second[`BHMAC_ADDR_MASK_BIT] ? low_second : 8'h00;
    assign lo_m1   = ((rx_in_data ^ low_first) & ~lo_mask) == 8'h00;
    assign lo_m2   = !high_second[`BHMAC_ADDR_MASK_BIT] && (rx_in_data == low_second);
    assign lo_grp  = (rx_in_data == `BHMAC_LOW_GROUP);

    // ==========================================================
    // receive frame walk
    logic             store;
    logic             wr_now;
    logic             set_pend;
    logic             pend_valid;
    logic [7:0]       pend_data;
    logic [7:0]       held;
    logic             end_d;
    logic [CNT_W-1:0] count;
    logic             ov_live;
    logic [CNT_W-1:0] next_count;
    logic             next_ov;
    logic             wr_any;
    logic             pool_hit;
    logic             accept_last;

    assign store = ext_mode[`BHMAC_EXT_STORE_ADDR];

    // per byte decision; the start byte always opens a fresh walk
    always_comb begin
        cur_state     = start ? bhmac_pkg::RX_IDLE : rx_state;
        next_rx_state = cur_state;
        wr_now        = 1'b0;
        set_pend      = 1'b0;
        if (cur_state == bhmac_pkg::RX_IDLE) begin
            if (!mode_reg[`BHMAC_MODE_RX_EN] || mode == bhmac_pkg::MODE_RES0
                    || mode == bhmac_pkg::MODE_RES1) begin
                cur_state = bhmac_pkg::RX_DROP;
            end else if (two_addr) begin
                cur_state = bhmac_pkg::RX_HIGH;
            end else if (lo_cmp) begin
                cur_state = bhmac_pkg::RX_LOW;
            end else begin
                cur_state = bhmac_pkg::RX_DATA;
            end
            next_rx_state = cur_state;
        end
        if (rx_in_valid) begin
            case (cur_state)
                bhmac_pkg::RX_HIGH: begin
                    if (hi_cmp && !(hi_m1 || hi_m2 || hi_grp)) begin
                        next_rx_state = bhmac_pkg::RX_DROP;
                    end else begin
                        next_rx_state = bhmac_pkg::RX_LOW;
                    end
                end
                bhmac_pkg::RX_LOW: begin
                    if (lo_cmp && !(lo_m1 || lo_m2 || lo_grp)) begin
                        next_rx_state = bhmac_pkg::RX_DROP;
                    end else begin
                        next_rx_state = bhmac_pkg::RX_DATA;
                        wr_now   = store;
                        set_pend = store && two_addr;
                    end
                end
                bhmac_pkg::RX_DATA: begin
                    wr_now = !rx_in_crc || ext_mode[`BHMAC_EXT_RX_CRC_KEEP];
                end
                bhmac_pkg::RX_DROP: next_rx_state = bhmac_pkg::RX_DROP;
                default:            next_rx_state = bhmac_pkg::RX_DROP;
            endcase
            if (rx_in_last) begin
                next_rx_state = bhmac_pkg::RX_IDLE;
            end
        end
    end

    assign accept_last = rx_in_valid && rx_in_last && (cur_state != bhmac_pkg::RX_DROP)
                      && !(cur_state == bhmac_pkg::RX_HIGH && hi_cmp && !(hi_m1 || hi_m2 || hi_grp))
                      && !(cur_state == bhmac_pkg::RX_LOW && lo_cmp && !(lo_m1 || lo_m2 || lo_grp));

    // walk state, held high byte and pending second address byte
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            rx_state   <= bhmac_pkg::RX_IDLE;
            held       <= 8'h00;
            pend_valid <= 1'b0;
            pend_data  <= 8'h00;
            end_d      <= 1'b0;
        end else if (receiver_reset_cmd) begin
            rx_state   <= bhmac_pkg::RX_IDLE;
            pend_valid <= 1'b0;
            end_d      <= 1'b0;
        end else begin
            rx_state   <= next_rx_state;
            pend_valid <= set_pend;
            end_d      <= accept_last;
            if (set_pend) begin
                pend_data <= rx_in_data;
            end
            if (rx_in_valid && cur_state == bhmac_pkg::RX_HIGH) begin
                held <= rx_in_data;
            end
        end
    end

    // fifo write: held high byte goes first, the second byte a cycle later
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            rx_fifo_valid <= 1'b0;
            rx_fifo_data  <= 8'h00;
        end else begin
            rx_fifo_valid <= (wr_now || pend_valid) && !receiver_reset_cmd;
            rx_fifo_data  <= pend_valid ? pend_data : (set_pend ? held : rx_in_data);
        end
    end

    // high and low match results, and command versus response in one-byte mode
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            high_match_result <= `BHMAC_RST_HIGH_RESULT;
            low_match_result  <= `BHMAC_RST_LOW_RESULT;
            low_match_command <= 1'b0;
        end else if (rx_in_valid) begin
            if (cur_state == bhmac_pkg::RX_HIGH && hi_cmp && (hi_m1 || hi_m2 || hi_grp)) begin
                high_match_result <= hi_m1 ? `BHMAC_HIGH_RES_FIRST :
                                     (hi_m2 ? `BHMAC_HIGH_RES_SECOND : `BHMAC_HIGH_RES_GROUP);
            end
            if (cur_state == bhmac_pkg::RX_LOW && lo_cmp && (lo_m1 || lo_m2 || lo_grp)) begin
                low_match_result  <= lo_m1 || lo_m2;
                low_match_command <= (mode == bhmac_pkg::MODE_NONAUTO1) && lo_m1;
            end
        end
    end

    // ==========================================================
    // receive byte count and events
    assign wr_any     = wr_now || pend_valid;
    assign next_count = (start ? {CNT_W{1'b0}} : count) + {{(CNT_W-1){1'b0}}, wr_any};
    // overflow once past the top count
    assign next_ov    = (!start && ov_live) || (wr_any && !start && (&count));
    assign pool_hit   = wr_any && !accept_last && !end_d && (next_count != {CNT_W{1'b0}})
                     && ((next_count[5:0] & rx_blk_mask) == 6'h00);

    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            count          <= {CNT_W{1'b0}};
            ov_live        <= 1'b0;
            rx_message_end <= 1'b0;
            rx_pool_full   <= 1'b0;
        end else begin
            count          <= next_count;
            ov_live        <= next_ov;
            rx_message_end <= end_d;
            rx_pool_full   <= pool_hit;
        end
    end

    // snapshot held until acknowledge or receiver reset; a new event beats the clear
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            snap_count <= {CNT_W{1'b0}};
            snap_ov    <= 1'b0;
        end else if (end_d || pool_hit) begin
            snap_count <= next_count;
            snap_ov    <= next_ov;
        end else if (rx_cmd) begin
            snap_count <= {CNT_W{1'b0}};
            snap_ov    <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    sequence s_end_seen;
        end_d ##1 rx_message_end;
    endsequence

    a_snap_on_end: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
        end_d |-> s_end_seen ##0 ({snap_ov, snap_count} == $past({next_ov, next_count})))
        else $error("count snapshot missing at message end");
    a_disabled_rx: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
        (start && !mode_reg[`BHMAC_MODE_RX_EN]) |=> !rx_fifo_valid)
        else $error("fifo written while receiver disabled");
    a_high_group: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
        (rx_in_valid && cur_state == bhmac_pkg::RX_HIGH && hi_cmp && hi_grp && !hi_m1 && !hi_m2)
        |=> high_match_result == 2'h1)
        else $error("high group address not reported");
    a_low_prog: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
        (rx_in_valid && cur_state == bhmac_pkg::RX_LOW && lo_cmp && lo_m1) |=> low_match_result)
        else $error("low programmed match not reported");
    a_miss_drops: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
        (rx_in_valid && !rx_in_last && cur_state == bhmac_pkg::RX_LOW && lo_cmp
         && !(lo_m1 || lo_m2 || lo_grp)) |=> rx_state == bhmac_pkg::RX_DROP && !rx_fifo_valid)
        else $error("unmatched frame not dropped");
    a_addr_unstored: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
        (rx_in_valid && cur_state == bhmac_pkg::RX_LOW && !store) |=> !rx_fifo_valid [*2])
        else $error("address stored while store is off");
    a_tx_blk_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
        (!tx_cmd && !$past(tx_cmd)) |=> $stable(tx_block_bytes))
        else $error("transmit block size changed without command");
    a_rx_blk_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
        (!rx_cmd && !$past(rx_cmd)) |=> $stable(rx_block_bytes))
        else $error("receive block size changed without command");
    a_idle_ones: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
        (tx_bit_strobe && !ext_mode[`BHMAC_EXT_FILL_SEL]) |=> tx_fill_bit)
        else $error("idle fill not ones");
    a_apb_answer: assert property (@(posedge ref_clk) disable iff (!rst_n_sync)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb answer not in access cycle");

endmodule : bhmac_mode_address_ctrl

// File: hdl/bhmac_pkg.sv
// types shared by the hdlc mode and address block
package bhmac_pkg;

    // message transfer modes
    typedef enum logic [2:0] {
        MODE_RES0      = 3'h0,
        MODE_RES1      = 3'h1,
        MODE_NONAUTO1  = 3'h2,
        MODE_NONAUTO2  = 3'h3,
        MODE_EXT_TRANS = 3'h4,
        MODE_TRANS2    = 3'h5,
        MODE_TRANS0    = 3'h6,
        MODE_TRANS1    = 3'h7
    } bhmac_mode_e;

    // receive frame walk
    typedef enum logic [2:0] {
        RX_IDLE,
        RX_HIGH,
        RX_LOW,
        RX_DATA,
        RX_DROP
    } bhmac_rx_state_e;

endpackage : bhmac_pkg

// File: test/bhmac_rx_src.sv
// serial side model: hands received bytes to the block at channel rate
module bhmac_rx_src (
    input  wire logic       ref_clk,
    output logic            rx_in_valid,
    output logic      [7:0] rx_in_data,
    output logic            rx_in_first,
    output logic            rx_in_last
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {rx_in_valid, rx_in_data, rx_in_first, rx_in_last} = 11'h000;
    // one byte then a gap; idle data is inverted so a stale byte never matches
    task automatic put(input logic [7:0] b, input logic f, input logic l);
        @(posedge ref_clk);
        rx_in_valid <= 1'b1;
        rx_in_data  <= b;
        rx_in_first <= f;
        rx_in_last  <= l;
        @(posedge ref_clk);
        rx_in_valid <= 1'b0;
        rx_in_first <= 1'b0;
        rx_in_last  <= 1'b0;
        rx_in_data  <= ~b;
        @(posedge ref_clk);
    endtask : put
endmodule : bhmac_rx_src

// File: test/tb_top.sv
// self-checking bench for the hdlc mode and address block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, crc = 0;
    logic [23:0] fd_log = 24'h000000;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_v;
    logic [5:0]  cmd = 6'h00;
    logic [7:0]  rxd, fd, fl;
    logic [6:0]  txb, rxb;
    logic [1:0]  hmr;
    logic        pready, pslverr, rd_e, rxv, rxf, rxl, fv, me, pf, lmr, lmc, cra, fill;
    int          failures = 0, num_checks = 0, n_fifo = 0, n_end = 0, cyc = 0, n_pool = 0;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
    initial forever #5 ref_clk = ~ref_clk;
    bhmac_rx_src i_src (.ref_clk(ref_clk), .rx_in_valid(rxv), .rx_in_data(rxd),
        .rx_in_first(rxf), .rx_in_last(rxl));
    // command strobes: 0 ack, 1 rx reset, 2 msg end, 3 tx reset, 4 transparent, 5 bit
    bhmac_mode_address_ctrl i_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_message_complete(cmd[0]), .receiver_reset_cmd(cmd[1]),
        .tx_message_end(cmd[2]), .transmitter_reset_cmd(cmd[3]),
        .tx_transparent_frame(cmd[4]), .rx_in_valid(rxv), .rx_in_data(rxd),
        .rx_in_first(rxf), .rx_in_last(rxl), .rx_in_crc(crc), .rx_fifo_valid(fv),
        .rx_fifo_data(fd), .rx_message_end(me), .rx_pool_full(pf),
        .high_match_result(hmr), .low_match_result(lmr), .low_match_command(lmc),
        .tx_block_bytes(txb), .rx_block_bytes(rxb), .tx_crc_append(cra),
        .tx_bit_strobe(cmd[5]), .tx_fill_bit(fill));
    // tally receive pulses; a hung bench ends as a failure
    always @(posedge ref_clk) begin
        n_fifo += (fv === 1'b1);
        n_end  += (me === 1'b1);
        n_pool += (pf === 1'b1);
        if (fv === 1'b1) fd_log = {fd_log[15:0], fd};
        if (++cyc == 20000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        rd_e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [9:0] i, input logic [7:0] e, input string n);
        apb(1'b0, i, 8'h00);
        `CHK(n, {1'b0, 24'h0, e}, {rd_e, rd_v})
    endtask : rd
    task automatic pulse(input int k);
        @(posedge ref_clk);
        cmd <= 6'h01 << k;
        @(posedge ref_clk);
        cmd <= 6'h00;
        repeat (3) @(posedge ref_clk);
    endtask : pulse
    task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        i_src.put(a, 1'b1, 1'b0);
        i_src.put(b, 1'b0, 1'b0);
        i_src.put(c, 1'b0, 1'b1);
        repeat (5) @(posedge ref_clk);
    endtask : frame
    task automatic check_reset();
        rd(10'h072, 8'hC0, "mode");
        rd(10'h073, 8'h00, "ext_mode");
        rd(10'h077, 8'h00, "count_high");
        apb(1'b0, 10'h07F, 8'h00);
        `CHK("unmapped", 1'b1, rd_e)
        repeat (3) pulse(5);
        `CHK("idle_fill", 1'b1, fill)
        apb(1'b1, 10'h073, 8'h01);
        repeat (5) pulse(5);
        for (int k = 0; k < 8; k++) begin
            pulse(5);
            fl = {fill, fl[7:1]};
        end
        `CHK("flag_fill", 8'h7E, fl)
    endtask : check_reset
    task automatic check_blocks();
        apb(1'b1, 10'h073, 8'h88);
        repeat (3) @(posedge ref_clk);
        `CHK("tx_blk_held", 7'h40, txb)
        `CHK("crc_off", 1'b0, cra)
        pulse(2);
        `CHK("tx_blk_end", 7'h20, txb)
        apb(1'b1, 10'h073, 8'h60);
        pulse(3);
        `CHK("tx_blk_rst", 7'h40, txb)
        `CHK("rx_blk_held", 7'h40, rxb)
        `CHK("crc_on", 1'b1, cra)
        apb(1'b1, 10'h073, 8'h80);
        pulse(4);
        `CHK("tx_blk_xtf", 7'h20, txb)
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 10'h073, 8'(k << 5));
            pulse(k % 2);
            `CHK("rx_blk", 7'h40 >> k, rxb)
        end
    endtask : check_blocks
    task automatic check_frames();
        apb(1'b1, 10'h072, 8'h68);
        apb(1'b1, 10'h073, 8'h10);
        apb(1'b1, 10'h075, 8'h24);
        apb(1'b1, 10'h074, 8'h5A);
        frame(8'h24, 8'h5A, 8'h11);
        `CHK("fifo_writes", 3, n_fifo)
        `CHK("fifo_order", 24'h245A11, fd_log)
        `CHK("high_first", 2'b10, hmr)
        `CHK("low_prog", 1'b1, lmr)
        rd(10'h076, 8'h03, "count_low");
        frame(8'h30, 8'h5A, 8'h11);
        `CHK("drop_end", 1, n_end)
        `CHK("drop_fifo", 3, n_fifo)
        frame(8'h24, 8'h33, 8'h11);
        `CHK("drop_low", 3, n_fifo)
        rd(10'h076, 8'h03, "count_kept");
        frame(8'hFC, 8'hFF, 8'h11);
        `CHK("group_high", 2'b01, hmr)
        `CHK("group_low", 1'b0, lmr)
        pulse(0);
        rd(10'h076, 8'h00, "count_ack");
        apb(1'b1, 10'h072, 8'h48);
        apb(1'b1, 10'h073, 8'h00);
        apb(1'b1, 10'h076, 8'h01);
        apb(1'b1, 10'h078, 8'h0F);
        frame(8'h55, 8'h11, 8'h22);
        `CHK("cmd_addr", 1'b1, lmc)
        `CHK("masked_low", 8, n_fifo)
        `CHK("addr_unstored", 24'h111122, fd_log)
        apb(1'b1, 10'h072, 8'hC8);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 10'h073, 8'(k << 2));
            i_src.put(8'h11, 1'b1, 1'b0);
            crc <= 1'b1;
            i_src.put(8'h22, 1'b0, 1'b1);
            crc <= 1'b0;
            repeat (5) @(posedge ref_clk);
            `CHK("crc_fifo", 9 + 2 * k, n_fifo)
        end
        apb(1'b1, 10'h073, 8'h60);
        pulse(1);
        for (int k = 0; k < 10; k++) i_src.put(8'(k), k == 0, k == 9);
        repeat (5) @(posedge ref_clk);
        `CHK("pool_full", 1, n_pool)
        rd(10'h076, 8'h0A, "count_long");
        rd(10'h077, 8'h00, "count_high_end");
        apb(1'b1, 10'h072, 8'hA8);
        frame(8'h00, 8'h5A, 8'h11);
        `CHK("trans2", 22, n_fifo)
        apb(1'b1, 10'h072, 8'h28);
        frame(8'h24, 8'h5A, 8'h11);
        `CHK("reserved", 7, n_end)
        apb(1'b1, 10'h072, 8'h60);
        frame(8'h24, 8'h5A, 8'h11);
        `CHK("rx_off", 7, n_end)
    endtask : check_frames
    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check_reset();
        check_blocks();
        check_frames();
        results();
    end
endmodule : tb_top
